/* adrc_consts.svh */
// Constants for the converter register decode block: field positions, codes and reset values.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ADRC_CONSTS_SVH
`define ADRC_CONSTS_SVH

// ---------------------------------------------------------------
// Serial word layout
// ---------------------------------------------------------------
`define ADRC_WORD_BITS 16
`define ADRC_DATA_BITS 14
`define ADRC_SEL_HI 15
`define ADRC_SEL_LO 14

// ---------------------------------------------------------------
// Control word fields
// ---------------------------------------------------------------
`define ADRC_CTL_RESET 14'h0000
`define ADRC_CTL_POWER_HI 9
`define ADRC_CTL_POWER_LO 8
`define ADRC_CTL_READ_HI 7
`define ADRC_CTL_READ_LO 6
`define ADRC_CTL_MODE1 5
`define ADRC_CTL_CONV 4
`define ADRC_CTL_KIND 3
`define ADRC_CTL_CSEL_HI 2
`define ADRC_CTL_CSEL_LO 1
`define ADRC_CTL_CALGO 0

// ---------------------------------------------------------------
// Calibration register file
// ---------------------------------------------------------------
`define ADRC_CAL_REGS 10
`define ADRC_CAL_GAIN 4'h0
`define ADRC_CAL_OFFSET 4'h1
`define ADRC_CAL_RESET 14'h0000
`define ADRC_TEST_RESET 14'h0000

`endif

/* adrc_pkg.sv */
// Types shared by the converter register decode block.
// Assumes adrc_consts.svh is on the include path.
`include "adrc_consts.svh"

package adrc_pkg;

  // Select code in the top two bits of a written word.
  typedef enum logic [1:0] {
    ADRC_WR_NONE = 2'h0,
    ADRC_WR_TEST = 2'h1,
    ADRC_WR_CAL = 2'h2,
    ADRC_WR_CTL = 2'h3
  } adrc_wsel_t;

  // Register returned by later reads.
  typedef enum logic [1:0] {
    ADRC_RD_RESULT = 2'h0,
    ADRC_RD_TEST = 2'h1,
    ADRC_RD_CAL = 2'h2,
    ADRC_RD_STATUS = 2'h3
  } adrc_rsel_t;

  // State held on the system clock.
  typedef struct packed {
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic [`ADRC_DATA_BITS-1:0] ctl;
    logic [`ADRC_DATA_BITS-1:0] test;
    logic [`ADRC_CAL_REGS-1:0][`ADRC_DATA_BITS-1:0] cal;
    logic [3:0] cal_ptr;
    logic [`ADRC_WORD_BITS-1:0] pub_word;
    logic pub_mode;
    logic pub_tog;
    logic conv_start;
    logic cal_start;
  } adrc_core_t;

  // State held on the serial clock that lives across frames.
  typedef struct packed {
    logic [`ADRC_WORD_BITS-2:0] shift;
    logic [`ADRC_WORD_BITS-1:0] word;
    logic tog;
    logic ps1;
    logic ps2;
    logic ack;
    logic [`ADRC_WORD_BITS-1:0] hold;
    logic hmode;
  } adrc_link_t;

  // State on the serial clock that is cleared between frames.
  typedef struct packed {
    logic [3:0] cnt;
    logic dout;
    logic din_o;
    logic din_oe_n;
  } adrc_frame_t;

endpackage

/* adrc_regs.sv */
// Register decode and control word logic of a serial converter.
// Assumes conversion and calibration engines on the system clock, and a host on the serial port.
`timescale 1ns/1ns
`include "adrc_consts.svh"

module adrc_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din_i,
  output logic din_o,
  output logic din_oe_n,
  output logic dout,
  input wire logic [`ADRC_DATA_BITS-1:0] conv_result,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic cal_done,
  output logic conv_start,
  output logic cal_start,
  output logic [1:0] power_code,
  output logic calibration_kind,
  output logic [1:0] cal_type,
  output logic [3:0] cal_index
);

  // ---------------------------------------------------------------
  // Calibration group decode
  // ---------------------------------------------------------------

  // Number of registers in each calibration group.
  function automatic logic [3:0] grp_len(input logic [1:0] grp);
    logic [3:0] n;
    n = 4'h1;
    if (grp == 2'h0) begin
      n = 4'hA;
    end else if (grp == 2'h1) begin
      n = 4'h2;
    end
    return n;
  endfunction

  // Physical register for a position inside a group; gain first, then offset, then DAC.
  function automatic logic [3:0] grp_reg(input logic [1:0] grp, input logic [3:0] ptr);
    logic [3:0] r;
    r = ptr;
    if (grp == 2'h2) begin
      r = `ADRC_CAL_OFFSET;
    end else if (grp == 2'h3) begin
      r = `ADRC_CAL_GAIN;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  adrc_pkg::adrc_core_t core_q;
  adrc_pkg::adrc_core_t core_d;
  adrc_pkg::adrc_link_t link_q;
  adrc_pkg::adrc_link_t link_d;
  adrc_pkg::adrc_frame_t frm_q;
  adrc_pkg::adrc_frame_t frm_d;
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic word_done;
  logic [3:0] cur_reg;
  logic busy;
  logic [`ADRC_WORD_BITS-1:0] rd_word;
  adrc_pkg::adrc_wsel_t wsel;
  adrc_pkg::adrc_rsel_t rsel;

  // ---------------------------------------------------------------
  // System clock side
  // ---------------------------------------------------------------

  // Decode helpers shared by the next-state logic and the checks.
  assign word_done = core_q.wr_s2 ^ core_q.wr_s3;
  assign wsel = adrc_pkg::adrc_wsel_t'(link_q.word[`ADRC_SEL_HI:`ADRC_SEL_LO]);
  assign rsel = adrc_pkg::adrc_rsel_t'(core_q.ctl[`ADRC_CTL_READ_HI:`ADRC_CTL_READ_LO]);
  assign cur_reg = grp_reg(core_q.ctl[`ADRC_CTL_CSEL_HI:`ADRC_CTL_CSEL_LO], core_q.cal_ptr);
  assign busy = conv_busy | core_q.ctl[`ADRC_CTL_CONV] | core_q.ctl[`ADRC_CTL_CALGO];

  // Word offered to the next read, chosen by the read select field.
  always_comb begin
    unique case (rsel)
      adrc_pkg::ADRC_RD_RESULT: rd_word = {2'h0, conv_result};
      adrc_pkg::ADRC_RD_TEST: rd_word = {2'h0, core_q.test};
      adrc_pkg::ADRC_RD_CAL: rd_word = {2'h0, core_q.cal[cur_reg]};
      adrc_pkg::ADRC_RD_STATUS: rd_word = {1'b0, busy, 4'h0, core_q.ctl[9:8], 2'h3,
                                           core_q.ctl[5], 1'b0, core_q.ctl[3:0]};
    endcase
  end

  // Next state: word arrival from the link, register writes and engine handshakes.
  always_comb begin
    core_d = core_q;
    core_d.wr_s1 = link_q.tog;
    core_d.wr_s2 = core_q.wr_s1;
    core_d.wr_s3 = core_q.wr_s2;
    core_d.conv_start = 1'b0;
    core_d.cal_start = 1'b0;
    if (conv_done) begin
      core_d.ctl[`ADRC_CTL_CONV] = 1'b0;
    end
    if (cal_done) begin
      core_d.ctl[`ADRC_CTL_CALGO] = 1'b0;
    end
    if (word_done) begin
      // Every frame is also a read cycle, so the mode bit drops unless rewritten.
      core_d.ctl[`ADRC_CTL_MODE1] = 1'b0;
      if (rsel == adrc_pkg::ADRC_RD_CAL && wsel != adrc_pkg::ADRC_WR_CAL) begin
        core_d.cal_ptr = (core_q.cal_ptr + 4'h1 >= grp_len(core_q.ctl[2:1])) ?
                         4'h0 : core_q.cal_ptr + 4'h1;
      end
      unique case (wsel)
        adrc_pkg::ADRC_WR_NONE: begin
        end
        adrc_pkg::ADRC_WR_TEST: begin
          core_d.test = link_q.word[`ADRC_DATA_BITS-1:0];
        end
        adrc_pkg::ADRC_WR_CAL: begin
          core_d.cal[cur_reg] = link_q.word[`ADRC_DATA_BITS-1:0];
          core_d.cal_ptr = (core_q.cal_ptr + 4'h1 >= grp_len(core_q.ctl[2:1])) ?
                           4'h0 : core_q.cal_ptr + 4'h1;
        end
        adrc_pkg::ADRC_WR_CTL: begin
          // A write here overrides a done pulse in the same cycle.
          core_d.ctl = link_q.word[`ADRC_DATA_BITS-1:0];
          core_d.cal_ptr = 4'h0;
          core_d.conv_start = link_q.word[`ADRC_CTL_CONV];
          core_d.cal_start = link_q.word[`ADRC_CTL_CALGO];
        end
      endcase
    end
    if (rd_word != core_q.pub_word || core_q.ctl[5] != core_q.pub_mode) begin
      core_d.pub_word = rd_word;
      core_d.pub_mode = core_q.ctl[`ADRC_CTL_MODE1];
      core_d.pub_tog = ~core_q.pub_tog;
    end
  end

  // System clock register with synchronous reset.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      core_q <= '0;
      core_q.ctl <= `ADRC_CTL_RESET;
      core_q.test <= `ADRC_TEST_RESET;
    end else begin
      core_q <= core_d;
    end
  end

  // Control outputs straight from the register, except cal_index, which passes through the group decode.
  assign conv_start = core_q.conv_start;
  assign cal_start = core_q.cal_start;
  assign power_code = core_q.ctl[`ADRC_CTL_POWER_HI:`ADRC_CTL_POWER_LO];
  assign calibration_kind = core_q.ctl[`ADRC_CTL_KIND];
  assign cal_type = core_q.ctl[`ADRC_CTL_CSEL_HI:`ADRC_CTL_CSEL_LO];
  assign cal_index = cur_reg;

  // ---------------------------------------------------------------
  // Serial clock side
  // ---------------------------------------------------------------

  // Reset brought into the serial domain; needs serial clock edges while asserted.
  always_ff @(posedge sclk) begin
    lrst_s1_q <= resetn;
    lrst_s2_q <= lrst_s1_q;
  end

  // Shift in, hand finished words over, and take the published read word at the first edge of a frame.
  always_comb begin
    link_d = link_q;
    link_d.ps1 = core_q.pub_tog;
    link_d.ps2 = link_q.ps1;
    if (!sync_n) begin
      link_d.shift = {link_q.shift[`ADRC_WORD_BITS-3:0], din_i};
      if (frm_q.cnt == 4'hF) begin
        link_d.word = {link_q.shift, din_i};
        link_d.tog = ~link_q.tog;
      end
      if (frm_q.cnt == 4'h0 && link_q.ps2 != link_q.ack) begin
        link_d.hold = core_q.pub_word;
        link_d.hmode = core_q.pub_mode;
        link_d.ack = link_q.ps2;
      end
    end
  end

  // Serial clock register for state kept across frames.
  always_ff @(posedge sclk) begin
    if (!lrst_s2_q) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // Bit counter and pin drivers; one bit per edge, most significant first.
  always_comb begin
    frm_d.cnt = frm_q.cnt + 4'h1;
    frm_d.dout = link_d.hold[4'hF - frm_q.cnt];
    frm_d.din_o = link_d.hold[4'hF - frm_q.cnt];
    frm_d.din_oe_n = ~link_d.hmode;
  end

  // Frame state cleared whenever the frame signal is high, so a partial word is dropped.
  always_ff @(posedge sclk or posedge sync_n) begin
    if (sync_n) begin
      frm_q.cnt <= 4'h0;
      frm_q.dout <= 1'b0;
      frm_q.din_o <= 1'b0;
      frm_q.din_oe_n <= 1'b1;
    end else begin
      frm_q <= frm_d;
    end
  end

  assign dout = frm_q.dout;
  assign din_o = frm_q.din_o;
  assign din_oe_n = frm_q.din_oe_n;

  // ---------------------------------------------------------------
  // Checks on the system clock
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // A finished word with the given select code.
  sequence wr_none_s;
    word_done && wsel == adrc_pkg::ADRC_WR_NONE;
  endsequence
  sequence wr_ctl_s;
    word_done && wsel == adrc_pkg::ADRC_WR_CTL;
  endsequence

  // Test and calibration registers do not change without a finished word.
  hold_idle_a: assert property (!word_done |=> $stable(core_q.test) &&
    $stable(core_q.cal)) else $error("register changed without a word");
  // Discarded words leave test and calibration alone.
  null_write_a: assert property (wr_none_s |=> $stable(core_q.test) &&
    $stable(core_q.cal)) else $error("select 00 modified a register");
  // Test writes land one cycle later.
  test_write_a: assert property (word_done && wsel == adrc_pkg::ADRC_WR_TEST |=>
    core_q.test == $past(link_q.word[13:0])) else $error("test write lost");
  // Control writes land and launch the requested conversion start pulse.
  ctl_write_a: assert property (wr_ctl_s |=> core_q.ctl == $past(link_q.word[13:0])
    && conv_start == $past(link_q.word[4])) else $error("control write lost");
  // The start pulse lasts exactly one cycle.
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  // Done without a control write clears the start bit.
  conv_clear_a: assert property (conv_done &&
    !(word_done && wsel == adrc_pkg::ADRC_WR_CTL) |=>
    !core_q.ctl[4]) else $error("conversion bit not cleared");
  // The mode bit drops after a frame that does not write it.
  mode_drop_a: assert property (word_done && wsel != adrc_pkg::ADRC_WR_CTL |=>
    !core_q.ctl[5]) else $error("mode bit survived a read");
  // Result reads carry two leading zeros.
  result_zero_a: assert property (rsel == adrc_pkg::ADRC_RD_RESULT |->
    rd_word[15:14] == 2'h0) else $error("result read lacks leading zeros");
  // Status reads show busy and ones in the read select bits.
  status_fmt_a: assert property (rsel == adrc_pkg::ADRC_RD_STATUS |->
    rd_word[7:6] == 2'h3 && rd_word[14] == busy) else $error("status word malformed");
  // The published word follows the read source within one cycle.
  pub_follow_a: assert property ($stable(rd_word) |=>
    core_q.pub_word == $past(rd_word)) else $error("read word not published");

endmodule

/* adrc_host.sv */
// Host model that drives the serial port of the register decode block.
// Assumes the bench resolves the shared data pin from the device's enable.
`timescale 1ns/1ns

module adrc_host (
  output logic sclk,
  output logic sync_n,
  output logic din,
  input wire logic dout,
  input wire logic din_oe_n,
  output logic drove
);
  // -------------------------------------------------------------
  // Serial frames
  // -------------------------------------------------------------
  // Lines start idle: frame high, serial clock low.
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
    drove = 1'b0;
  end

  // Clock pulses with the frame high, so the serial side can settle.
  task automatic idle(input int n);
    repeat (n) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
  endtask

  // Shifts a word out MSB first and takes a read bit at every falling edge.
  task automatic frame(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    drove = 1'b0;
    sync_n = 1'b0;
    for (int k = 1; k <= nbits; k++) begin
      din = w[16-k];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
      r[16-k] = dout;
      if (din_oe_n === 1'b0) drove = 1'b1;
    end
    #32 sync_n = 1'b1;
    din = ~din; // A released pin must not keep showing its last bit.
  endtask
endmodule

/* adrc_regs_tb.sv */
// Self-checking bench for the register decode block.
// Assumes adrc_regs and adrc_host are compiled beforehand.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module adrc_regs_tb;
  typedef struct packed {
    logic [15:0] w;
    logic [15:0] rd;
    logic [1:0] pw;
    logic kd;
    logic [1:0] ty;
    logic [3:0] ix;
  } adrc_tb_row_t;
  // Word written, next read word, power code, kind, type, calibration index.
  localparam adrc_tb_row_t ROWS [8] = '{
    '{16'h4ABC, 16'h1A5C, 2'h0, 1'b0, 2'h0, 4'h0},
    '{16'hC040, 16'h0ABC, 2'h0, 1'b0, 2'h0, 4'h0},
    '{16'h0123, 16'h0ABC, 2'h0, 1'b0, 2'h0, 4'h0},
    '{16'hC3CA, 16'h03CA, 2'h3, 1'b1, 2'h1, 4'h0},
    '{16'hC000, 16'h1A5C, 2'h0, 1'b0, 2'h0, 4'h0},
    '{16'hC086, 16'h0000, 2'h0, 1'b0, 2'h3, 4'h0},
    '{16'h8155, 16'h0155, 2'h0, 1'b0, 2'h3, 4'h0},
    '{16'hC084, 16'h0000, 2'h0, 1'b0, 2'h2, 4'h1}};
  logic clock, resetn, sclk, sync_n, host_din, din_i, din_o, din_oe_n, dout, drove;
  logic [13:0] conv_result;
  logic conv_busy, conv_done, cal_done, conv_start, cal_start, calibration_kind;
  logic [1:0] power_code, cal_type;
  logic [3:0] cal_index;
  logic [15:0] rd;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int conv_n = 0;
  int cal_n = 0;

  // -------------------------------------------------------------
  // Device, host and shared pin
  // -------------------------------------------------------------
  // The data pin carries the device's bit whenever it enables its driver.
  assign din_i = din_oe_n ? host_din : din_o;

  adrc_regs dut (.clock(clock), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
    .din_i(din_i), .din_o(din_o), .din_oe_n(din_oe_n), .dout(dout),
    .conv_result(conv_result), .conv_busy(conv_busy), .conv_done(conv_done),
    .cal_done(cal_done), .conv_start(conv_start), .cal_start(cal_start),
    .power_code(power_code), .calibration_kind(calibration_kind), .cal_type(cal_type),
    .cal_index(cal_index));

  adrc_host host (.sclk(sclk), .sync_n(sync_n), .din(host_din), .dout(dout),
    .din_oe_n(din_oe_n), .drove(drove));

  // -------------------------------------------------------------
  // Clock, start counters and hang guard
  // -------------------------------------------------------------
  // System clock of 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Counts start pulses and cuts a hung run short.
  always @(posedge clock) begin
    cycles++;
    if (conv_start === 1'b1) conv_n++;
    if (cal_start === 1'b1) cal_n++;
    if (cycles == 10000) begin
      fail_count++;
      stop_test();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One whole frame, then time and idle pulses for the result to publish.
  task automatic xfer(input logic [15:0] w);
    host.frame(w, 16, rd);
    repeat (12) @(negedge clock);
    host.idle(3);
  endtask

  // One-cycle completion pulse from the conversion or calibration engine.
  task automatic pulse(input bit cal);
    @(negedge clock);
    if (cal) cal_done = 1'b1;
    else conv_done = 1'b1;
    @(negedge clock);
    cal_done = 1'b0;
    conv_done = 1'b0;
    // Idle serial edges carry the new published word across before the next frame.
    host.idle(3);
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  // Reset, table rows, then a partial word, starts and interface mode 1.
  initial begin
    resetn = 1'b0;
    conv_result = 14'h1A5C;
    conv_busy = 1'b0;
    conv_done = 1'b0;
    cal_done = 1'b0;
    fork
      host.idle(3);
      repeat (20) @(negedge clock);
    join
    `CHK("power_code", 2'h0, power_code)
    `CHK("conv_start", 1'b0, conv_start)
    `CHK("din_oe_n", 1'b1, din_oe_n)
    resetn = 1'b1;
    host.idle(2);
    for (int i = 0; i < 8; i++) begin
      xfer(ROWS[i].w);
      xfer(16'h0000);
      `CHK("read_word", ROWS[i].rd, rd)
      `CHK("power_code", ROWS[i].pw, power_code)
      `CHK("calibration_kind", ROWS[i].kd, calibration_kind)
      `CHK("cal_type", ROWS[i].ty, cal_type)
      `CHK("cal_index", ROWS[i].ix, cal_index)
    end
    xfer(16'hC0C0);
    host.frame(16'hC3C0, 8, rd);
    repeat (12) @(negedge clock);
    xfer(16'h0000);
    `CHK("partial_word", 16'h00C0, rd)
    `CHK("power_code", 2'h0, power_code)
    conv_n = 0;
    xfer(16'hC0D0);
    `CHK("conv_starts", 1, conv_n)
    xfer(16'h0000);
    `CHK("busy_conv", 16'h40C0, rd)
    pulse(1'b0);
    xfer(16'h0000);
    `CHK("idle_conv", 16'h00C0, rd)
    @(negedge clock);
    conv_busy = 1'b1;
    host.idle(3);
    xfer(16'h0000);
    `CHK("busy_pin", 16'h40C0, rd)
    @(negedge clock);
    conv_busy = 1'b0;
    host.idle(3);
    cal_n = 0;
    xfer(16'hC0C1);
    `CHK("cal_starts", 1, cal_n)
    xfer(16'h0000);
    `CHK("busy_cal", 16'h40C1, rd)
    pulse(1'b1);
    xfer(16'h0000);
    `CHK("idle_cal", 16'h00C0, rd)
    xfer(16'hC0E0);
    xfer(16'h0000);
    `CHK("mode1_word", 16'h00E0, rd)
    `CHK("mode1_drive", 1'b1, drove)
    xfer(16'h0000);
    `CHK("mode2_word", 16'h00C0, rd)
    `CHK("mode2_drive", 1'b0, drove)
    stop_test();
  end
endmodule
